// ===== eps_pkg.sv
// Constants for the speed speed_bypass_select and single-word programming register block
package eps_pkg;
   localparam int DW = 16;
   localparam int CFG_WORDS = 7;
   localparam int CFG_AW = 3;

   localparam logic [7:0] OFS_ID        = 8'h08;
   localparam logic [7:0] OFS_UNUSED_LO = 8'h09;
   localparam logic [7:0] OFS_UNUSED_HI = 8'h2F;
   localparam logic [7:0] OFS_SPEED     = 8'h30;
   localparam logic [7:0] OFS_KEY       = 8'h31;
   localparam logic [7:0] OFS_STATUS    = 8'h32;
   localparam logic [7:0] OFS_ADDR      = 8'h33;
   localparam logic [7:0] OFS_WDATA     = 8'h34;
   localparam logic [7:0] OFS_CTRL      = 8'h35;
   localparam logic [7:0] OFS_RDATA     = 8'h36;
   localparam logic [7:0] CFG_FIRST     = 8'h90;
   localparam logic [7:0] CFG_LAST      = 8'h96;

   localparam logic [15:0] UNLOCK_KEY = 16'hC0DE;
   localparam logic [15:0] RST_WORD   = 16'h0000;

   localparam int BYPASS_BIT  = 15;
   localparam int SPEED_MSB   = 8;
   localparam int MIRROR_BIT  = 12;
   localparam int REFRESH_BIT = 8;
   localparam int DIR_BIT     = 2;
   localparam int KIND_MSB    = 1;
   localparam int READY_BIT   = 0;

   typedef enum logic [1:0] {
      EPS_KIND_OFF    = 2'h0,
      EPS_KIND_SINGLE = 2'h1,
      EPS_KIND_MASS   = 2'h2,
      EPS_KIND_BAD    = 2'h3
   } eps_kind_e;

   localparam int CLK_NS = 40;
   localparam int NVM_ACCESS_NS = 200;
   localparam logic [7:0] NVM_ACCESS_CYC = 8'((NVM_ACCESS_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ===== eps_mem_if.sv
// Port bundle between the register block and the nonvolatile word store
`timescale 1ns/1ns
interface eps_mem_if #(
   parameter int DW = 16,
   parameter int AW = 3
);
   logic          en;
   logic          we;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport ctl (output en, output we, output addr, output wdata, input rdata);
   modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// ===== eps_nvm_mem.sv
// Nonvolatile configuration word store with registered read data
`timescale 1ns/1ns
module eps_nvm_mem #(
   parameter int DEPTH = 7,
   parameter int DW    = 16
) (
   input wire logic clk,
   input wire logic ce,
   eps_mem_if.mem   port
);
   typedef struct packed {
      logic [DEPTH-1:0][DW-1:0] words;
      logic [DW-1:0]            rdata;
   } eps_mem_s;

   eps_mem_s mem_reg;
   eps_mem_s mem_next;

   // Contents survive reset, as a nonvolatile array would
   always_comb begin
      mem_next = mem_reg;
      if (ce && port.en && (int'(port.addr) < DEPTH)) begin
         if (port.we) begin
            mem_next.words[port.addr] = port.wdata;
         end else begin
            mem_next.rdata = mem_reg.words[port.addr];
         end
      end
   end

   always_ff @(posedge clk) begin
      mem_reg <= mem_next;
   end

   assign port.rdata = mem_reg.rdata;
endmodule

// ===== eps_regs.sv
// Speed speed_bypass_select and single-word nonvolatile programming register block
// How it works
// - Identification upper byte holds die identifier
// - Identification lower byte holds revision code
// - Addresses 0x09 to 0x2F hold nothing
// - Bypass bit selects host-written speed command
// - Nine-bit host speed value, bits 8:0
// - Only correct unlock key opens configuration space to writes and transfers; reads need no key
// - Status bit 0 shows store availability
// - Address field picks the single-word location
// - Write data register goes to addressed word
// - Access kind: off, single, mass; never 11
// - Direction bit: zero reads, one writes
// - Single read lands in read data register
// - Mirror enable serves and uses shadow copy
`timescale 1ns/1ns
module eps_regs #(
   parameter logic [7:0] DIE_ID   = 8'h5A, // Arbitrary value
   parameter logic [7:0] REV_CODE = 8'h3C, // Arbitrary value
   parameter logic [7:0] NVM_CYC  = eps_pkg::NVM_ACCESS_CYC
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   input  wire logic [8:0]  speed_in,
   output wire logic [15:0] rd_data,
   output wire logic        rd_valid,
   output wire logic [8:0]  speed_cmd,
   output wire logic        nvm_available,
   output wire logic        mirror_active
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} eps_fsm_e;

   typedef struct packed {
      logic                                  bypass;
      logic [8:0]                            host_speed;
      logic [15:0]                           key;
      logic [7:0]                            addr;
      logic [15:0]                           wval;
      logic                                  mirror;
      logic [1:0]                            kind;
      logic                                  dir;
      logic [15:0]                           rval;
      logic [eps_pkg::CFG_WORDS-1:0][15:0]   shadow;
      eps_fsm_e                              fsm;
      logic [eps_pkg::CFG_AW-1:0]            idx;
      logic                                  mass;
      logic                                  op_dir;
      logic [7:0]                            cnt;
      logic                                  cap;
      logic                                  rd_pend;
      logic [7:0]                            rd_addr;
      logic [15:0]                           rd_data;
      logic                                  rd_valid;
      logic [8:0]                            speed_cmd;
      logic                                  ready;
   } eps_state_s;

   eps_state_s st_reg;
   eps_state_s st_next;

   eps_mem_if #(.DW(eps_pkg::DW), .AW(eps_pkg::CFG_AW)) mem ();

   eps_nvm_mem #(.DEPTH(eps_pkg::CFG_WORDS), .DW(eps_pkg::DW)) u_mem (
      .clk  (clk),
      .ce   (ce),
      .port (mem.mem)
   );

   function automatic logic is_cfg(input logic [7:0] a);
      return (a >= eps_pkg::CFG_FIRST) && (a <= eps_pkg::CFG_LAST);
   endfunction

   function automatic logic [eps_pkg::CFG_AW-1:0] cfg_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - eps_pkg::CFG_FIRST;
      return d[eps_pkg::CFG_AW-1:0];
   endfunction

   logic unlocked;
   assign unlocked = (st_reg.key == eps_pkg::UNLOCK_KEY);

   always_comb begin
      st_next = st_reg;
      mem.en = 1'b0;
      mem.we = 1'b0;
      mem.addr = '0;
      mem.wdata = '0;
      if (ce) begin
         st_next.rd_valid = 1'b0;
         // Register writes; reserved bits are dropped here
         if (reg_wr) begin
            unique case (reg_addr)
               eps_pkg::OFS_SPEED: begin
                  st_next.bypass = reg_wdata[eps_pkg::BYPASS_BIT];
                  st_next.host_speed = reg_wdata[eps_pkg::SPEED_MSB:0];
               end
               eps_pkg::OFS_KEY: begin
                  st_next.key = reg_wdata;
               end
               eps_pkg::OFS_ADDR: begin
                  st_next.addr = reg_wdata[7:0];
               end
               eps_pkg::OFS_WDATA: begin
                  st_next.wval = reg_wdata;
               end
               eps_pkg::OFS_CTRL: begin
                  st_next.mirror = reg_wdata[eps_pkg::MIRROR_BIT];
                  st_next.dir = reg_wdata[eps_pkg::DIR_BIT];
                  if (reg_wdata[eps_pkg::KIND_MSB:0] != eps_pkg::EPS_KIND_BAD) begin
                     st_next.kind = reg_wdata[eps_pkg::KIND_MSB:0];
                  end
                  // Start a transfer only when open and idle
                  if (unlocked && (st_reg.fsm == ST_IDLE)) begin
                     if (reg_wdata[eps_pkg::REFRESH_BIT]) begin
                        st_next.fsm = ST_ISSUE;
                        st_next.mass = 1'b1;
                        st_next.op_dir = 1'b0;
                        st_next.idx = '0;
                     end else if (reg_wdata[eps_pkg::KIND_MSB:0] == eps_pkg::EPS_KIND_SINGLE
                                  && is_cfg(st_reg.addr)) begin
                        st_next.fsm = ST_ISSUE;
                        st_next.mass = 1'b0;
                        st_next.op_dir = reg_wdata[eps_pkg::DIR_BIT];
                        st_next.idx = cfg_index(st_reg.addr);
                     end else if (reg_wdata[eps_pkg::KIND_MSB:0] == eps_pkg::EPS_KIND_MASS) begin
                        st_next.fsm = ST_ISSUE;
                        st_next.mass = 1'b1;
                        st_next.op_dir = reg_wdata[eps_pkg::DIR_BIT];
                        st_next.idx = '0;
                     end
                  end
               end
               default: begin
                  if (is_cfg(reg_addr) && unlocked) begin
                     st_next.shadow[cfg_index(reg_addr)] = reg_wdata;
                  end
               end
            endcase
         end

         // Host reads of the store take the port ahead of the sequencer
         if (reg_rd && is_cfg(reg_addr)) begin
            mem.en = 1'b1;
            mem.addr = cfg_index(reg_addr);
         end

         // Read answer: data one cycle after the request is taken
         if (st_reg.rd_pend) begin
            st_next.rd_valid = 1'b1;
            st_next.rd_pend = 1'b0;
            unique case (st_reg.rd_addr)
               eps_pkg::OFS_ID: st_next.rd_data = {DIE_ID, REV_CODE};
               eps_pkg::OFS_SPEED: begin
                  st_next.rd_data = {st_reg.bypass, 6'h00, st_reg.host_speed};
               end
               eps_pkg::OFS_KEY: st_next.rd_data = st_reg.key;
               eps_pkg::OFS_STATUS: st_next.rd_data = {15'h0000, st_reg.ready};
               eps_pkg::OFS_ADDR: st_next.rd_data = {8'h00, st_reg.addr};
               eps_pkg::OFS_WDATA: st_next.rd_data = st_reg.wval;
               eps_pkg::OFS_CTRL: begin
                  st_next.rd_data = {3'h0, st_reg.mirror, 9'h000, st_reg.dir, st_reg.kind};
               end
               eps_pkg::OFS_RDATA: st_next.rd_data = st_reg.rval;
               default: begin
                  if (is_cfg(st_reg.rd_addr)) begin
                     st_next.rd_data = st_reg.mirror ? st_reg.shadow[cfg_index(st_reg.rd_addr)]
                                                     : mem.rdata;
                  end else begin
                     st_next.rd_data = eps_pkg::RST_WORD;
                  end
               end
            endcase
         end
         if (reg_rd) begin
            st_next.rd_pend = 1'b1;
            st_next.rd_addr = reg_addr;
         end

         // Sequencer for single-word and whole-space transfers
         unique case (st_reg.fsm)
            ST_IDLE: begin
            end
            ST_ISSUE: begin
               if (!reg_rd) begin
                  mem.en = 1'b1;
                  mem.we = st_reg.op_dir;
                  mem.addr = st_reg.idx;
                  mem.wdata = st_reg.mass ? st_reg.shadow[st_reg.idx] : st_reg.wval;
                  st_next.cnt = NVM_CYC - 8'h01;
                  st_next.cap = !st_reg.op_dir;
                  st_next.fsm = ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (st_reg.cap) begin
                  st_next.cap = 1'b0;
                  if (st_reg.mass) begin
                     st_next.shadow[st_reg.idx] = mem.rdata;
                  end else begin
                     st_next.rval = mem.rdata;
                  end
               end
               if (st_reg.cnt != 8'h00) begin
                  st_next.cnt = st_reg.cnt - 8'h01;
               end else if (st_reg.mass && (int'(st_reg.idx) != eps_pkg::CFG_WORDS - 1)) begin
                  st_next.idx = st_reg.idx + 3'h1;
                  st_next.fsm = ST_ISSUE;
               end else begin
                  st_next.fsm = ST_IDLE;
               end
            end
            default: begin
               st_next.fsm = ST_IDLE;
            end
         endcase

         st_next.ready = (st_next.fsm == ST_IDLE);
         st_next.speed_cmd = st_reg.bypass ? st_reg.host_speed : speed_in;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data       = st_reg.rd_data;
   assign rd_valid      = st_reg.rd_valid;
   assign speed_cmd     = st_reg.speed_cmd;
   assign nvm_available = st_reg.ready;
   assign mirror_active = st_reg.mirror;

   // Checks
   logic [15:0] shadow0;
   assign shadow0 = st_reg.shadow[0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_id_die_byte: assert property (
      ce && reg_rd && reg_addr == eps_pkg::OFS_ID ##1 ce |=> rd_valid && rd_data[15:8] == DIE_ID)
      else $error("die identifier byte wrong");

   a_id_rev_byte: assert property (
      ce && reg_rd && reg_addr == eps_pkg::OFS_ID ##1 ce |=> rd_data[7:0] == REV_CODE)
      else $error("revision byte wrong");

   a_unused_reads_zero: assert property (
      ce && reg_rd && reg_addr >= eps_pkg::OFS_UNUSED_LO && reg_addr <= eps_pkg::OFS_UNUSED_HI
      ##1 ce |=> rd_valid && rd_data == 16'h0000)
      else $error("unused address read not zero");

   a_bypass_speed_out: assert property (
      ce && st_reg.bypass |=> speed_cmd == $past(st_reg.host_speed))
      else $error("bypass speed not taken from host value");

   a_speed_value_store: assert property (
      ce && reg_wr && reg_addr == eps_pkg::OFS_SPEED
      |=> st_reg.host_speed == $past(reg_wdata[8:0]))
      else $error("speed value not stored");

   a_key_gates_start: assert property (
      ce && reg_wr && reg_addr == eps_pkg::OFS_CTRL && !unlocked && st_reg.fsm == ST_IDLE
      |=> st_reg.fsm == ST_IDLE)
      else $error("transfer started without key");

   a_busy_not_ready: assert property (
      ce && st_reg.fsm != ST_IDLE |-> !nvm_available)
      else $error("availability shown while busy");

   a_single_write_port: assert property (
      ce && st_reg.fsm == ST_ISSUE && !st_reg.mass && st_reg.op_dir && !reg_rd
      |-> mem.en && mem.we && mem.wdata == st_reg.wval && mem.addr == cfg_index(st_reg.addr))
      else $error("single write not sent to addressed word");

   a_kind_bad_kept: assert property (
      ce && reg_wr && reg_addr == eps_pkg::OFS_CTRL && reg_wdata[1:0] == 2'h3
      |=> st_reg.kind == $past(st_reg.kind))
      else $error("illegal access kind accepted");

   a_read_captured: assert property (
      ce && st_reg.fsm == ST_WAIT && st_reg.cap && !st_reg.mass
      |=> st_reg.rval == $past(mem.rdata))
      else $error("single read data not captured");

   a_mirror_served: assert property (
      ce && reg_rd && reg_addr == eps_pkg::CFG_FIRST && st_reg.mirror && !reg_wr
      ##1 ce && !reg_wr |=> rd_data == $past(shadow0))
      else $error("mirror copy not returned");

   c_single_write: cover property (
      st_reg.fsm == ST_ISSUE && !st_reg.mass && st_reg.op_dir ##[1:20] st_reg.fsm == ST_IDLE);
   c_single_read: cover property (
      st_reg.fsm == ST_WAIT && st_reg.cap && !st_reg.mass);
   c_mass_done: cover property (
      st_reg.mass && int'(st_reg.idx) == eps_pkg::CFG_WORDS - 1 && st_reg.fsm == ST_WAIT);
   c_bypass_on: cover property (st_reg.bypass && ce);
endmodule

// ===== eps_host_model.sv
// Host controller model driving the register port of the block
`timescale 1ns/1ns
module eps_host_model (
   input  wire logic        clk,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic      [15:0] reg_wdata,
   output logic             reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 16'h0000;
      reg_rd = 1'b0;
   end

   // Released address and data lines show the inverse of the last value, never a stale copy; both strobes go low
   task automatic release_bus();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask

   // Reserved bits are sent as zero by the callers, except the random words written to unused addresses
   // Each request starts just after an edge, so back to back calls never drive a line twice
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      release_bus();
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
      int n;
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      release_bus();
      ok = 1'b0;
      d = 16'h0000;
      for (n = 0; n < 4 && !ok; n++) begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1) begin
            ok = 1'b1;
            d = rd_data;
         end
      end
   endtask
endmodule

// ===== tb.sv
// Self-checking bench for the speed speed_bypass_select and programming registers
`timescale 1ns/1ns
module tb;
   localparam logic [7:0] DIE  = 8'hA5; // Arbitrary value
   localparam logic [7:0] REV  = 8'h17; // Arbitrary value
   localparam logic [7:0] NCYC = 8'h02;
   logic        clk, rstn, ce, reg_wr, reg_rd, rd_valid, nvm_available, mirror_active;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, rd_data, d;
   logic [8:0]  speed_in, speed_cmd;
   logic [31:0] seed;
   logic [15:0] mem_model [7];
   int          n_errors, compares, cycles, i;

   eps_regs #(.DIE_ID(DIE), .REV_CODE(REV), .NVM_CYC(NCYC)) i_dut (
      .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .speed_in(speed_in), .rd_data(rd_data),
      .rd_valid(rd_valid), .speed_cmd(speed_cmd), .nvm_available(nvm_available),
      .mirror_active(mirror_active));

   eps_host_model i_host (
      .clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction

   function automatic logic [15:0] exp_speed(input logic [15:0] w, input logic [8:0] s);
      return w[15] ? {7'h00, w[8:0]} : {7'h00, s};
   endfunction

   task automatic final_report();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] v;
      logic        ok;
      i_host.rd(a, v, ok);
      chk("rd_valid", {15'h0000, ok}, 16'h0001);
      chk($sformatf("reg %h", a), v, exp);
   endtask

   // Writes the control word and checks whether a transfer starts and how long it runs
   task automatic prog(input logic [15:0] ctrl, input int words);
      int n;
      i_host.wr(eps_pkg::OFS_CTRL, ctrl);
      @(posedge clk);
      #1;
      if (words == 0) begin
         chk("nvm_available idle", {15'h0000, nvm_available}, 16'h0001);
      end else begin
         chk("nvm_available busy", {15'h0000, nvm_available}, 16'h0000);
         n = 0;
         while (nvm_available !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk("busy cycles", 16'(n), 16'(words * (1 + NCYC) - 1));
      end
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         final_report();
      end
   end

   initial begin
      ce = 1'b1;
      rstn = 1'b0;
      speed_in = 9'h000;
      seed = 32'hFEBCFFCF;
      n_errors = 0;
      compares = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      #1;
      rstn = 1'b1;
      rdchk(eps_pkg::OFS_ID, {DIE, REV});
      for (i = 8'h30; i <= 8'h34; i++) begin
         rdchk(8'(i), (i == 8'h32) ? 16'h0001 : 16'h0000);
      end
      i_host.wr(eps_pkg::OFS_STATUS, 16'h0000);
      rdchk(eps_pkg::OFS_STATUS, 16'h0001);
      $display("test reset done");

      for (i = 0; i < 6; i++) begin
         seed = xs(seed);
         d = (i == 0) ? 16'h0009 : (i == 1) ? 16'h002F : 16'(8'h0A + seed[7:0] % 8'h25);
         i_host.wr(d[7:0], seed[31:16]);
         rdchk(d[7:0], 16'h0000);
      end
      $display("test unused range done");

      for (i = 0; i < 8; i++) begin
         seed = xs(seed);
         d = (i == 0) ? 16'h81FF : (i == 1) ? 16'h0100 : seed[15:0] & 16'h81FF;
         speed_in = seed[24:16];
         i_host.wr(eps_pkg::OFS_SPEED, d);
         @(posedge clk);
         #1;
         chk("speed_cmd", {7'h00, speed_cmd}, exp_speed(d, speed_in));
         rdchk(eps_pkg::OFS_SPEED, d);
      end
      // A write offered while the enable is low must leave the register alone
      ce = 1'b0;
      i_host.wr(eps_pkg::OFS_SPEED, ~d & 16'h81FF);
      ce = 1'b1;
      rdchk(eps_pkg::OFS_SPEED, d);
      $display("test speed done");

      // The host starts a transfer only once the key is in and the store is idle
      i_host.wr(eps_pkg::OFS_KEY, 16'hC0DF);
      i_host.wr(eps_pkg::OFS_ADDR, 16'h0090);
      i_host.wr(eps_pkg::OFS_WDATA, 16'h1234);
      prog(16'h0005, 0);
      i_host.wr(eps_pkg::OFS_KEY, eps_pkg::UNLOCK_KEY);
      rdchk(eps_pkg::OFS_KEY, eps_pkg::UNLOCK_KEY);
      i_host.wr(eps_pkg::OFS_ADDR, 16'h0097);
      prog(16'h0005, 0);
      prog(16'h0004, 0);
      for (i = 0; i < 7; i++) begin
         seed = xs(seed);
         mem_model[i] = seed[15:0];
         i_host.wr(eps_pkg::OFS_ADDR, 16'(8'h90 + i));
         rdchk(eps_pkg::OFS_ADDR, 16'(8'h90 + i));
         i_host.wr(eps_pkg::OFS_WDATA, mem_model[i]);
         prog(16'h0005, 1);
      end
      for (i = 6; i >= 0; i--) begin
         i_host.wr(eps_pkg::OFS_ADDR, 16'(8'h90 + i));
         prog(16'h0001, 1);
         rdchk(eps_pkg::OFS_RDATA, mem_model[i]);
         rdchk(8'(8'h90 + i), mem_model[i]);
      end
      $display("test single word done");

      i_host.wr(eps_pkg::OFS_CTRL, 16'h1000);
      @(posedge clk);
      #1;
      chk("mirror_active", {15'h0000, mirror_active}, 16'h0001);
      i_host.wr(eps_pkg::CFG_FIRST, ~mem_model[0]);
      rdchk(eps_pkg::CFG_FIRST, ~mem_model[0]);
      prog(16'h1002, 7);
      for (i = 0; i < 7; i++) begin
         rdchk(8'(8'h90 + i), mem_model[i]);
      end
      prog(16'h1007, 0);
      rdchk(eps_pkg::OFS_CTRL, 16'h1006);
      for (i = 0; i < 7; i++) begin
         seed = xs(seed);
         mem_model[i] = seed[15:0];
         i_host.wr(8'(8'h90 + i), mem_model[i]);
      end
      prog(16'h1006, 7);
      i_host.wr(eps_pkg::CFG_FIRST, ~mem_model[0]);
      prog(16'h1100, 7);
      rdchk(eps_pkg::CFG_FIRST, mem_model[0]);
      i_host.wr(eps_pkg::OFS_CTRL, 16'h0000);
      @(posedge clk);
      #1;
      chk("mirror_active", {15'h0000, mirror_active}, 16'h0000);
      for (i = 0; i < 7; i++) begin
         rdchk(8'(8'h90 + i), mem_model[i]);
      end
      $display("test mirror and mass done");
      final_report();
   end
endmodule
